// *** rtl/wph_pkg.sv ***
// Constants, register map and carrier types for the warning output and hold timer.
// Assumes a single 20 MHz clock and a plain address/strobe register port.
//
// Overview of operation
// - Warning output is active exactly while overload or regenerative overload warning is present.
// - Warning output is active low: low means warning, high means no warning.
// - Top digit of output_select_two routes warning: 0 none, 1..3 pair; default 0000.
// - Several signals routed to one terminal pair drive it as a logical OR.
// - Code select 0: code lines show alarm codes only, never warning codes.
// - Code select 1: code lines show warning codes, alarm code overrides on alarm.
// - Overload drives code line 0 low; regenerative overload drives only line 1 low.
// - Momentary hold time accepts 20 to 1000 ms, default 20 ms.
// - Main supply loss keeps motor on below hold time, turns it off on reaching it.
// - Undervoltage alarm during supply loss is raised at once, whatever the hold time.
// - Control supply loss is a plain power-off, never subject to the hold time.
// - The four status outputs go to the pair named by their output_select_one digit, default 3211; position_out_n_a uses sel_three.
package wph_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_SEL_ONE   = 8'h00;
  localparam logic [7:0] OFS_SEL_TWO   = 8'h04;
  localparam logic [7:0] OFS_SEL_THREE = 8'h08;
  localparam logic [7:0] OFS_CODE_SEL  = 8'h0C;
  localparam logic [7:0] OFS_HOLD_TIME = 8'h10;
  localparam logic [7:0] OFS_STATUS    = 8'h14;
  localparam logic [7:0] OFS_IRQ_STS   = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h1C;

  // Reset values
  localparam logic [15:0] SEL_ONE_RST   = 16'h3211;
  localparam logic [15:0] SEL_TWO_RST   = 16'h0000;
  localparam logic [15:0] SEL_THREE_RST = 16'h0000;
  localparam logic        CODE_SEL_RST  = 1'b0;

  // Field positions
  localparam int WARN_DIGIT_LSB = 12;
  localparam int POSITION_OUT_N_A_DIGIT_LSB = 0;
  localparam int NUM_PAIRS      = 3;
  localparam int NUM_ROUTED     = 6;

  // Hold time limits in milliseconds
  localparam logic [15:0] HOLD_MIN_MS = 16'h0014;
  localparam logic [15:0] HOLD_MAX_MS = 16'h03E8;
  localparam logic [9:0]  HOLD_RST_MS = 10'h014;

  // Timing: one millisecond in clock cycles
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  // Code line patterns, line 0 in bit 0, low = asserted
  localparam logic [2:0] CODE_IDLE  = 3'h7;
  localparam logic [2:0] CODE_OVLD  = 3'h6;
  localparam logic [2:0] CODE_REGEN = 3'h5;

  // Interrupt bits
  localparam int IRQ_LOSS   = 0;
  localparam int IRQ_EXPIRE = 1;
  localparam int IRQ_UV     = 2;
  localparam int IRQ_CTRL   = 3;
  localparam int IRQ_WARN   = 4;
  localparam int IRQ_W      = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    HS_RUN,
    HS_HOLD,
    HS_OFF
  } wph_hold_t;

  // Status inputs from the drive logic, same clock
  typedef struct packed {
    logic pos_done;
    logic speed_match;
    logic running;
    logic servo_ready;
    logic position_out_n_a_pos;
    logic ovld_warn;
    logic regen_warn;
  } wph_stat_t;

  typedef struct packed {
    logic [15:0] sel_one;
    logic [15:0] sel_two;
    logic [15:0] sel_three;
    logic        code_sel;
    logic [9:0]  hold_ms;
    logic [IRQ_W-1:0] irq_sts;
    logic [IRQ_W-1:0] irq_mask;
    logic [1:0]  main_sync;
    logic [1:0]  ctrl_sync;
    wph_hold_t   hstate;
    logic [14:0] tick_cnt;
    logic [9:0]  elapsed;
    logic        uv_alarm;
    logic        ctrl_lost;
    logic        motor_on;
    logic        warn_d;
    logic [2:0]  pair_n;
    logic [2:0]  code_n;
    logic [31:0] rdata;
  } wph_state_t;

endpackage : wph_pkg

// *** rtl/wph_warn_hold.sv ***
// Warning output routing, code line mux and main supply hold timer.
// Assumes status inputs come from logic on ref_clk; supply sense pins are asynchronous.
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
module wph_warn_hold
  import wph_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = MS_CYCLES
) (
  // Clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Drive status, same clock
  input  wire wph_stat_t   stat_in,
  input  wire logic        alarm_active,
  input  wire logic [2:0]  alarm_code_n,
  input  wire logic        uv_detect,
  // Supply sense pins, high while supply is present
  input  wire logic        main_ok_pin,
  input  wire logic        ctrl_ok_pin,
  // Outputs
  output logic [2:0]       pair_out_n,
  output logic [2:0]       code_line_n,
  output logic             motor_on,
  output logic             uv_alarm,
  output logic             ctrl_lost,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  wph_state_t r;
  wph_state_t r_next;

  logic [NUM_ROUTED-1:0] route_sig;
  logic [3:0]            route_dig [NUM_ROUTED];
  logic [NUM_PAIRS-1:0]  pair_hit;
  logic                  warn_any;

  // Warning present on either cause
  assign warn_any = stat_in.ovld_warn | stat_in.regen_warn;

  // Routed signals and their allocation digits
  assign route_sig = {warn_any, stat_in.position_out_n_a_pos, stat_in.servo_ready,
                      stat_in.running, stat_in.speed_match, stat_in.pos_done};
  assign route_dig[0] = r.sel_one[3:0];
  assign route_dig[1] = r.sel_one[7:4];
  assign route_dig[2] = r.sel_one[11:8];
  assign route_dig[3] = r.sel_one[15:12];
  // Position_out_n_a output stays off until software allocates it
  assign route_dig[4] = r.sel_three[POSITION_OUT_N_A_DIGIT_LSB +: 4];
  // Warning allocation digit
  assign route_dig[5] = r.sel_two[WARN_DIGIT_LSB +: 4];

  ////////////////////////////////////////////////////////////////////////////
  // Per pair: OR of every signal allocated to it
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PAIRS; gp++) begin : g_pair
      logic [NUM_ROUTED-1:0] sel_hit;
      for (genvar gs = 0; gs < NUM_ROUTED; gs++) begin : g_sig
        // Digit 0 matches no pair, so it leaves the signal unrouted
        assign sel_hit[gs] = route_sig[gs] & (route_dig[gs] == 4'(gp + 1));
      end
      assign pair_hit[gp] = |sel_hit;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [15:0]      wval;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic             main_ok;
    logic             ctrl_ok;
    logic [9:0]       elapsed_inc;
    wval        = reg_wdata[15:0];
    irq_set     = '0;
    irq_clr     = '0;
    main_ok     = r.main_sync[1];
    ctrl_ok     = r.ctrl_sync[1];
    elapsed_inc = r.elapsed + 10'h001;
    r_next      = r;

    if (clk_en) begin
      // Two-stage synchronisers for the supply sense pins
      r_next.main_sync = {r.main_sync[0], main_ok_pin};
      r_next.ctrl_sync = {r.ctrl_sync[0], ctrl_ok_pin};

      // Register writes
      if (reg_wr) begin
        case (reg_addr)
          OFS_SEL_ONE:   r_next.sel_one   = wval;
          OFS_SEL_TWO:   r_next.sel_two   = wval;
          OFS_SEL_THREE: r_next.sel_three = wval;
          OFS_CODE_SEL:  r_next.code_sel  = reg_wdata[0];
          OFS_HOLD_TIME: begin
            // Out of range values are clamped, never stored raw
            if (wval < HOLD_MIN_MS) begin
              r_next.hold_ms = HOLD_MIN_MS[9:0];
            end else if (wval > HOLD_MAX_MS) begin
              r_next.hold_ms = HOLD_MAX_MS[9:0];
            end else begin
              r_next.hold_ms = wval[9:0];
            end
          end
          OFS_IRQ_STS:   irq_clr = reg_wdata[IRQ_W-1:0];
          OFS_IRQ_MASK:  r_next.irq_mask = reg_wdata[IRQ_W-1:0];
          default: ;
        endcase
      end

      // Register reads, data in the following cycle only
      r_next.rdata = '0;
      if (reg_rd) begin
        case (reg_addr)
          OFS_SEL_ONE:   r_next.rdata = {16'h0000, r.sel_one};
          OFS_SEL_TWO:   r_next.rdata = {16'h0000, r.sel_two};
          OFS_SEL_THREE: r_next.rdata = {16'h0000, r.sel_three};
          OFS_CODE_SEL:  r_next.rdata = {31'h00000000, r.code_sel};
          OFS_HOLD_TIME: r_next.rdata = {22'h000000, r.hold_ms};
          OFS_STATUS:    r_next.rdata = {24'h000000, r.ctrl_lost, r.uv_alarm,
                                         (r.hstate == HS_HOLD), r.motor_on,
                                         ctrl_ok, main_ok, r.warn_d, 1'b0};
          OFS_IRQ_STS:   r_next.rdata = {27'h0000000, r.irq_sts};
          OFS_IRQ_MASK:  r_next.rdata = {27'h0000000, r.irq_mask};
          default:       r_next.rdata = '0;
        endcase
      end

      // Hold timer state machine
      case (r.hstate)
        HS_RUN: begin
          if (!ctrl_ok) begin
            r_next.hstate = HS_OFF;
          end else if (!main_ok) begin
            // Fresh count at every new loss
            r_next.hstate   = HS_HOLD;
            r_next.tick_cnt = '0;
            r_next.elapsed  = '0;
            irq_set[IRQ_LOSS] = 1'b1;
          end
        end
        HS_HOLD: begin
          if (!ctrl_ok) begin
            // Control power gone: no ride-through at all
            r_next.hstate = HS_OFF;
          end else if (uv_detect) begin
            // Undervoltage does not wait for the hold time
            r_next.hstate   = HS_OFF;
            r_next.uv_alarm = 1'b1;
            irq_set[IRQ_UV] = 1'b1;
          end else if (main_ok) begin
            // Early return: back to running, no alarm, no event
            r_next.hstate   = HS_RUN;
            r_next.tick_cnt = '0;
            r_next.elapsed  = '0;
          end else if (r.tick_cnt == 15'(TICK_CYCLES - 1)) begin
            r_next.tick_cnt = '0;
            r_next.elapsed  = elapsed_inc;
            // Loss has lasted the full hold time
            if (elapsed_inc >= r.hold_ms) begin
              r_next.hstate       = HS_OFF;
              irq_set[IRQ_EXPIRE] = 1'b1;
            end
          end else begin
            r_next.tick_cnt = r.tick_cnt + 15'h0001;
          end
        end
        HS_OFF: begin
          // Restart only with both supplies back and no undervoltage
          if (main_ok && ctrl_ok && !uv_detect) begin
            r_next.hstate   = HS_RUN;
            r_next.uv_alarm = 1'b0;
          end
        end
        default: r_next.hstate = HS_OFF;
      endcase

      // Motor stays on while running or riding through a loss
      r_next.motor_on = ctrl_ok &&
                        ((r_next.hstate == HS_RUN) || (r_next.hstate == HS_HOLD));

      // Control supply loss handled as power-off
      r_next.ctrl_lost = !ctrl_ok;
      if (!ctrl_ok && !r.ctrl_lost) begin
        irq_set[IRQ_CTRL] = 1'b1;
      end

      // Warning rise event
      r_next.warn_d = warn_any;
      if (warn_any && !r.warn_d) begin
        irq_set[IRQ_WARN] = 1'b1;
      end

      // Sticky status: a new event beats a clear in the same cycle
      r_next.irq_sts = (r.irq_sts & ~irq_clr) | irq_set;

      // Terminal pairs: closed (low) while any routed signal is active
      r_next.pair_n = ~pair_hit;

      // Code lines
      if (alarm_active) begin
        r_next.code_n = alarm_code_n;
      end else if (!r.code_sel) begin
        r_next.code_n = CODE_IDLE;
      end else if (stat_in.ovld_warn) begin
        r_next.code_n = CODE_OVLD;
      end else if (stat_in.regen_warn) begin
        r_next.code_n = CODE_REGEN;
      end else begin
        r_next.code_n = CODE_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; supplies assumed present at reset to avoid a false event
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r.sel_one   <= SEL_ONE_RST;
      r.sel_two   <= SEL_TWO_RST;
      r.sel_three <= SEL_THREE_RST;
      r.code_sel  <= CODE_SEL_RST;
      r.hold_ms   <= HOLD_RST_MS;
      r.irq_sts   <= '0;
      r.irq_mask  <= '0;
      r.main_sync <= 2'h3;
      r.ctrl_sync <= 2'h3;
      r.hstate    <= HS_OFF;
      r.tick_cnt  <= '0;
      r.elapsed   <= '0;
      r.uv_alarm  <= 1'b0;
      r.ctrl_lost <= 1'b0;
      r.motor_on  <= 1'b0;
      r.warn_d    <= 1'b0;
      r.pair_n    <= 3'h7;
      r.code_n    <= CODE_IDLE;
      r.rdata     <= '0;
    end else begin
      r <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata   = r.rdata;
  assign pair_out_n  = r.pair_n;
  assign code_line_n = r.code_n;
  assign motor_on    = r.motor_on;
  assign uv_alarm    = r.uv_alarm;
  assign ctrl_lost   = r.ctrl_lost;
  // Level interrupt, high while any unmasked sticky bit is set
  assign irq         = |(r.irq_sts & r.irq_mask);

endmodule : wph_warn_hold

// *** testbench/wph_warn_hold_props.sv ***
// Checker: terminal routing, code lines and hold timer as seen at the ports.
// Assumes one clock; routing registers are shadowed from bus writes.
`timescale 1ns/1ps
module wph_warn_hold_props
  import wph_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = MS_CYCLES
) (
  // Clock and bus
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        clk_en,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Drive status and supplies
  input wire wph_stat_t   stat_in,
  input wire logic        alarm_active,
  input wire logic [2:0]  alarm_code_n,
  input wire logic        uv_detect,
  input wire logic        main_ok_pin,
  input wire logic        ctrl_ok_pin,
  // Outputs
  input wire logic [2:0]  pair_out_n,
  input wire logic [2:0]  code_line_n,
  input wire logic        motor_on,
  input wire logic        uv_alarm,
  input wire logic        ctrl_lost,
  input wire logic        irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [15:0] s1, s2, s3;
  logic        cs;
  logic [31:0] low_cnt;
  logic [2:0]  pair_x, code_x;
  wire         wen = clk_en && reg_wr;
  ////////////////////////////////////////////////////////////////////////////
  // Shadows follow bus writes; low_cnt counts samples with the main pin low
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {s1, s2, s3, cs} <= {SEL_ONE_RST, SEL_TWO_RST, SEL_THREE_RST, CODE_SEL_RST};
      low_cnt <= 32'h0;
    end else if (clk_en) begin
      if (wen && reg_addr == OFS_SEL_ONE) s1 <= reg_wdata[15:0];
      if (wen && reg_addr == OFS_SEL_TWO) s2 <= reg_wdata[15:0];
      if (wen && reg_addr == OFS_SEL_THREE) s3 <= reg_wdata[15:0];
      if (wen && reg_addr == OFS_CODE_SEL) cs <= reg_wdata[0];
      low_cnt <= main_ok_pin ? 32'h0 : low_cnt + 32'h1;
    end
  end
  // Expected levels; digits 4..F route nowhere, like 0
  always_comb begin
    pair_x = 3'h7;
    for (int p = 1; p <= NUM_PAIRS; p++) begin
      if ((s1[3:0] == 4'(p) && stat_in.pos_done) || (s1[7:4] == 4'(p) && stat_in.speed_match)
          || (s1[11:8] == 4'(p) && stat_in.running) || (s1[15:12] == 4'(p) && stat_in.servo_ready)
          || (s2[15:12] == 4'(p) && (stat_in.ovld_warn || stat_in.regen_warn))
          || (s3[3:0] == 4'(p) && stat_in.position_out_n_a_pos)) begin
        pair_x[p-1] = 1'h0;
      end
    end
    code_x = alarm_active ? alarm_code_n : !cs ? CODE_IDLE : stat_in.ovld_warn ? CODE_OVLD
           : stat_in.regen_warn ? CODE_REGEN : CODE_IDLE;
  end
  ////////////////////////////////////////////////////////////////////////////
  pair_route_a: assert property ($past(clk_en && !sys_rst) |->
    pair_out_n == $past(pair_x)) else $error("terminal pair level wrong");
  code_mux_a: assert property ($past(clk_en && !sys_rst) |->
    code_line_n == $past(code_x)) else $error("code line level wrong");
  hold_range_a: assert property (clk_en && reg_rd && reg_addr == OFS_HOLD_TIME |=>
    reg_rdata >= 32'(HOLD_MIN_MS) && reg_rdata <= 32'(HOLD_MAX_MS)) else $error("hold out of range");
  ctrl_seen_a: assert property ((!ctrl_ok_pin && clk_en)[*4] |=> ctrl_lost)
    else $error("control loss not flagged");
  ctrl_off_a: assert property ($rose(ctrl_lost) |-> !motor_on)
    else $error("motor on after control loss");
  uv_now_a: assert property ((!main_ok_pin)[*4] ##0 (uv_detect && motor_on && clk_en)
    |=> uv_alarm && !motor_on) else $error("undervoltage not immediate");
  hold_min_a: assert property ($fell(motor_on) && !uv_alarm && !ctrl_lost
    |-> low_cnt >= 32'(20 * TICK_CYCLES)) else $error("motor off before hold time");
  hold_back_a: assert property ((main_ok_pin && ctrl_ok_pin && !uv_detect && clk_en)[*4]
    ##0 motor_on |=> motor_on) else $error("motor off with supplies present");
  // Main scenarios
  cover property ($fell(motor_on) && !uv_alarm && !ctrl_lost);
  cover property ($rose(uv_alarm));
  cover property ($rose(ctrl_lost));
endmodule : wph_warn_hold_props
bind wph_warn_hold wph_warn_hold_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (.ref_clk, .sys_rst,
  .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .stat_in, .alarm_active,
  .alarm_code_n, .uv_detect, .main_ok_pin, .ctrl_ok_pin, .pair_out_n, .code_line_n, .motor_on,
  .uv_alarm, .ctrl_lost, .irq);

// *** testbench/wph_host_model.sv ***
// Host controller model reading the photocoupler terminal pairs.
// Assumes the host samples the terminals on the drive clock.
`timescale 1ns/1ps
module wph_host_model #(
  parameter int POSITION_OUT_N_A_PAIR = 1
) (
  // Clock and terminals
  input wire logic       ref_clk,
  input wire logic [2:0] pair_out_n,
  // What the host sees
  output logic     [2:0] term_closed,
  output logic           position_out_n_a_seen
);
  // Coupler conducts while the terminal is low; adds one sample of delay
  always_ff @(posedge ref_clk) term_closed <= ~pair_out_n;
  // Position_out_n_a output only read from the pair the host allocated it to
  assign position_out_n_a_seen = term_closed[POSITION_OUT_N_A_PAIR-1];
endmodule : wph_host_model

// *** testbench/wph_warn_hold_test.sv ***
// Bench for warning routing, code lines and hold timer, driven over the register port.
// Assumes a shortened millisecond tick so hold times stay short.
`timescale 1ns/1ps
module wph_warn_hold_test;
  import wph_pkg::*;
  localparam int TK = 4;
  logic ref_clk, sys_rst, clk_en, reg_wr, reg_rd, alarm_active, uv_detect, main_ok_pin, ctrl_ok_pin;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [2:0]  alarm_code_n, pair_out_n, code_line_n, term_closed, exp_c, exp_p;
  logic        motor_on, uv_alarm, ctrl_lost, irq, position_out_n_a_seen;
  wph_stat_t   stat_in;
  int          errors, n_tests, n;
  logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h40};
  logic [31:0] rv [8] = '{32'h3211, 32'h0, 32'h0, 32'h0, 32'h14, 32'h1C, 32'h0, 32'h0};
  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  wph_warn_hold #(.TICK_CYCLES(TK)) i_dut (.ref_clk, .sys_rst, .clk_en, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .stat_in, .alarm_active, .alarm_code_n, .uv_detect,
    .main_ok_pin, .ctrl_ok_pin, .pair_out_n, .code_line_n, .motor_on, .uv_alarm, .ctrl_lost, .irq);
  wph_host_model #(.POSITION_OUT_N_A_PAIR(1)) i_host (.ref_clk, .pair_out_n, .term_closed, .position_out_n_a_seen);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Bus cycles end on an edge so the next strobe is never set twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1 chk("reg_rdata", e, reg_rdata);
    @(posedge ref_clk);
  endtask : rd
  // Bounded wait on motor_on (0), uv_alarm (1) or ctrl_lost (2)
  task automatic wt(input int s, input logic v, input int lim);
    n = 0;
    #1;
    while ((s == 0 ? motor_on : s == 1 ? uv_alarm : ctrl_lost) !== v) begin
      if (n == lim) begin
        errors++;
        print_verdict();
      end
      @(posedge ref_clk);
      #1 n++;
    end
    // Leave on an edge so the caller's next drive lands right after it
    @(posedge ref_clk);
  endtask : wt
  task automatic print_verdict();
    if (errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {errors, n_tests, sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {stat_in, alarm_active, uv_detect, main_ok_pin, ctrl_ok_pin, clk_en} = 12'h7;
    alarm_code_n = 3'h2;
    sys_rst = 1'h1;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'h0;
    @(posedge ref_clk);
    wr(8'h40, 32'hFFFF);
    foreach (ra[i]) rd(ra[i], rv[i]);
    // Warning route digits 0 to 3, each with every code select and alarm combination
    for (int i = 0; i < 16; i++) begin
      wr(OFS_SEL_TWO, {16'h0, 4'(i % 4), 12'h0});
      wr(OFS_CODE_SEL, 32'(i / 4 % 2));
      alarm_active <= 1'(i / 8);
      for (int w = 0; w < 3; w++) begin
        stat_in <= '{ovld_warn: (w == 1), regen_warn: (w == 2), default: 1'h0};
        repeat (3) @(posedge ref_clk);
        exp_c = i >= 8 ? 3'h2 : (i < 4 || w == 0) ? CODE_IDLE : w == 1 ? CODE_OVLD : CODE_REGEN;
        exp_p = (w > 0 && i % 4 > 0) ? 3'(1 << (i % 4 - 1)) : 3'h0;
        chk("term_closed", 32'(exp_p), 32'(term_closed));
        chk("code_line_n", 32'(exp_c), 32'(code_line_n));
      end
    end
    // Reordered status routing; two signals share pair 3, position_out_n_a output on pair 1
    wr(OFS_SEL_ONE, 32'h0123);
    wr(OFS_SEL_THREE, 32'h1);
    stat_in <= '{pos_done: 1'h1, position_out_n_a_pos: 1'h1, ovld_warn: 1'h1, default: 1'h0};
    repeat (3) @(posedge ref_clk);
    chk("term_closed", 32'h5, 32'(term_closed));
    chk("position_out_n_a_seen", 32'h1, 32'(position_out_n_a_seen));
    {stat_in, alarm_active} <= '0;
    for (int i = 0; i < 5; i++) begin
      wr(OFS_HOLD_TIME, 32'(i * 500 + 5));
      rd(OFS_HOLD_TIME, i > 1 ? 32'h3E8 : i == 1 ? 32'h1F9 : 32'h14);
    end
    // Short loss is counted but does not expire; interrupt masked, then unmasked
    wr(OFS_IRQ_STS, 32'h1F);
    main_ok_pin <= 1'h0;
    repeat (40) @(posedge ref_clk);
    main_ok_pin <= 1'h1;
    repeat (6) @(posedge ref_clk);
    rd(OFS_IRQ_STS, 32'h1);
    chk("irq", 32'h0, 32'(irq));
    wr(OFS_IRQ_MASK, 32'h1);
    chk("irq", 32'h1, 32'(irq));
    wr(OFS_IRQ_STS, 32'h1);
    chk("irq", 32'h0, 32'(irq));
    // Loss of just under the hold time, then a fresh loss timed to expiry
    for (int h = 20; h <= 25; h += 5) begin
      wr(OFS_HOLD_TIME, 32'(h));
      main_ok_pin <= 1'h0;
      repeat (h * TK - 8) @(posedge ref_clk);
      main_ok_pin <= 1'h1;
      repeat (6) @(posedge ref_clk);
      chk("motor_on", 32'h1, 32'(motor_on));
      main_ok_pin <= 1'h0;
      wt(0, 1'h0, h * TK + 10);
      chk("hold_cycles", 32'h1, 32'(n >= h * TK && n <= h * TK + 5));
      main_ok_pin <= 1'h1;
      wt(0, 1'h1, 10);
    end
    // Undervoltage during a loss and control supply loss skip the hold time
    main_ok_pin <= 1'h0;
    repeat (10) @(posedge ref_clk);
    uv_detect <= 1'h1;
    wt(1, 1'h1, 4);
    chk("motor_on", 32'h0, 32'(motor_on));
    {uv_detect, main_ok_pin} <= 2'h1;
    wt(0, 1'h1, 10);
    ctrl_ok_pin <= 1'h0;
    wt(2, 1'h1, 5);
    chk("motor_on", 32'h0, 32'(motor_on));
    ctrl_ok_pin <= 1'h1;
    wt(0, 1'h1, 10);
    // Enable low freezes the port: a write then is ignored
    clk_en <= 1'h0;
    wr(OFS_HOLD_TIME, 32'h64);
    clk_en <= 1'h1;
    rd(OFS_HOLD_TIME, 32'h19);
    print_verdict();
  end
endmodule : wph_warn_hold_test
